/* File: pfs_mux.sv */
// pfs_mux: pin function selection for ports A-D, port data/direction
// registers and port A wake-up detection.
// assumes pin inputs already synchronous to ref_clk; the peripherals
// and the pad wire resolution live outside this module.
//
// Notes on behaviour
// - A3: 01 LCD frontplane 14, 10 reference voltage, else GPIO.
// - A2: 01 crystal pin 1, else GPIO.
// - A1: 01 LCD frontplane 15, 10 ADC input 0, else GPIO.
// - A0: 01 crystal pin 2, else GPIO.
// - A7: 01 LCD frontplane 10, else GPIO also feeding timer clock.
// - A6: 01 LCD frontplane 11, 10 UART receive, else GPIO.
// - A5: 01 LCD frontplane 12, 10 UART transmit, else GPIO.
// - A4: 01 LCD frontplane 13, 10 auxiliary output, else GPIO.
// - B3: 01 LCD frontplane 19, else GPIO also usable as interrupt.
// - B2..B0: 01 frontplane 18..16, 10 ADC 3..1, else GPIO.
// - B7..B4: 01 LCD backplane 3..0, else GPIO.
// - C3..C0: 01 LCD frontplane 3..0, else GPIO.
// - C7,C6: 01 frontplane 7,6, else GPIO; C6 also interrupt.
// - C5,C4: 01 frontplane 5,4, 10 UART transmit/receive, else GPIO.
// - D1: 01 LCD frontplane 8, else GPIO.
// - D0: 00 GPIO, 01 frontplane 9, 10 timer, 11 inverted timer.
// - selections clear at reset; unused select bits read zero.
// - routing bit 1 picks interrupt source: 0 B3, 1 C6.
// - routing bit 0 picks receive source: 0 A6, 1 C4; rest zero.
// - data latches and direction bits reset to all ones.
// - bit set/clear reads whole port, modifies bit, writes byte.
// - in sleep, falling edge on wake-enabled port A GPIO input wakes.
// - direction bit 1 input, 0 push-pull output.
`timescale 1ns/10ps
module pfs_mux
  import pfs_pkg::*;
(
  input  wire logic                  ref_clk,  // system clock
  input  wire logic                  resetn,   // async reset, active low
  input  wire logic [7:0]            addr,     // register address
  input  wire logic [7:0]            wdata,    // write data / bit index
  input  wire logic                  wr,       // write strobe
  input  wire logic                  rd,       // read strobe
  input  wire logic                  bit_set,  // qualifies wr as bit set
  input  wire logic                  bit_clr,  // qualifies wr as bit clear
  output logic      [7:0]            rdata,    // read data, cycle after rd
  input  wire logic [NUM_PINS-1:0]   pin_in,   // pad levels
  output logic      [NUM_PINS-1:0]   pin_out,  // pad drive levels
  output logic      [NUM_PINS-1:0]   pin_oe_n, // pad enable, low drives
  input  wire pfs_pkg::pfs_drive_t   drive,    // peripheral pin levels
  output pfs_pkg::pfs_periph_t       periph,   // routed peripheral inputs
  output pfs_pkg::pfs_analog_t       analog,   // analog switch enables
  input  wire logic                  sleep,    // sleep or idle mode
  output logic                       wake      // wake-up pulse
);

  // ----------------------------------------------------------------
  // routing table
  // ----------------------------------------------------------------
  // one table for every pin keeps the decode in one place; any code a pin
  // does not use falls through to plain gpio
  function automatic pfs_route_t route(input int pin, input logic [1:0] code);
    pfs_route_t r;
    r = '{PFS_FN_GPIO, 5'h00};
    if (code == CODE_LCD) begin
      case (pin)
        0:       r = '{PFS_FN_XTAL, 5'h01};
        1:       r = '{PFS_FN_LCDF, 5'h0F};
        2:       r = '{PFS_FN_XTAL, 5'h00};
        3:       r = '{PFS_FN_LCDF, 5'h0E};
        4:       r = '{PFS_FN_LCDF, 5'h0D};
        5:       r = '{PFS_FN_LCDF, 5'h0C};
        6:       r = '{PFS_FN_LCDF, 5'h0B};
        7:       r = '{PFS_FN_LCDF, 5'h0A};
        8:       r = '{PFS_FN_LCDF, 5'h10};
        9:       r = '{PFS_FN_LCDF, 5'h11};
        10:      r = '{PFS_FN_LCDF, 5'h12};
        11:      r = '{PFS_FN_LCDF, 5'h13};
        12:      r = '{PFS_FN_LCDB, 5'h00};
        13:      r = '{PFS_FN_LCDB, 5'h01};
        14:      r = '{PFS_FN_LCDB, 5'h02};
        15:      r = '{PFS_FN_LCDB, 5'h03};
        16:      r = '{PFS_FN_LCDF, 5'h00};
        17:      r = '{PFS_FN_LCDF, 5'h01};
        18:      r = '{PFS_FN_LCDF, 5'h02};
        19:      r = '{PFS_FN_LCDF, 5'h03};
        20:      r = '{PFS_FN_LCDF, 5'h04};
        21:      r = '{PFS_FN_LCDF, 5'h05};
        22:      r = '{PFS_FN_LCDF, 5'h06};
        23:      r = '{PFS_FN_LCDF, 5'h07};
        24:      r = '{PFS_FN_LCDF, 5'h09};
        25:      r = '{PFS_FN_LCDF, 5'h08};
        default: r = '{PFS_FN_GPIO, 5'h00};
      endcase
    end else if (code == CODE_ALT) begin
      case (pin)
        1:       r = '{PFS_FN_ADC,  5'h00};
        3:       r = '{PFS_FN_VREF, 5'h00};
        4:       r = '{PFS_FN_AUX,  5'h00};
        5:       r = '{PFS_FN_TX,   5'h00};
        6:       r = '{PFS_FN_RX,   5'h00};
        8:       r = '{PFS_FN_ADC,  5'h01};
        9:       r = '{PFS_FN_ADC,  5'h02};
        10:      r = '{PFS_FN_ADC,  5'h03};
        20:      r = '{PFS_FN_RX,   5'h00};
        21:      r = '{PFS_FN_TX,   5'h00};
        24:      r = '{PFS_FN_TMR,  5'h00};
        default: r = '{PFS_FN_GPIO, 5'h00};
      endcase
    end else if (code == CODE_ALT2) begin
      if (pin == PIN_D0) begin
        r = '{PFS_FN_TMRN, 5'h00};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // all registers but the reset synchroniser in one word; rdata and pad outputs are
  // copies held here so every port leaves straight from a flop
  typedef struct packed {
    logic [NUM_SEL-1:0][7:0]          sel;
    logic [1:0]                       in_route;
    logic [NUM_PORTS-1:0][PORT_W-1:0] data;
    logic [NUM_PORTS-1:0][PORT_W-1:0] dir;
    logic [PORT_W-1:0]                wake_en;
    logic [PORT_W-1:0]                pa_prev;
    logic [7:0]                       rdata;
    logic [NUM_PINS-1:0]              pin_out;
    logic [NUM_PINS-1:0]              pin_oe_n;
    pfs_periph_t                      periph;
    pfs_analog_t                      analog;
    logic                             wake;
  } pfs_state_t;

  // pa_prev starts high like an idle pad, so a pad held low as reset ends reads as a fall
  localparam pfs_state_t STATE_RESET = '{
    sel:      {NUM_SEL{SEL_RESET}},
    in_route: 2'h0,
    data:     {NUM_PORTS{PORT_RESET}},
    dir:      {NUM_PORTS{PORT_RESET}},
    wake_en:  8'h00,
    pa_prev:  8'hFF,
    rdata:    8'h00,
    pin_out:  {NUM_PINS{1'b1}},
    pin_oe_n: {NUM_PINS{1'b1}},
    periph:   '0,
    analog:   '0,
    wake:     1'b0
  };

  pfs_state_t                       st;
  pfs_state_t                       next_st;
  logic       [1:0]                 rst_sync;
  logic                             rst_n;
  logic       [NUM_PORTS-1:0][7:0]  pin_byte;

  assign rst_n    = rst_sync[1];
  assign pin_byte = {6'h00, pin_in[25:24], pin_in[23:16], pin_in[15:8], pin_in[7:0]};

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // assertion stays asynchronous; release waits two edges so that no flop
  // sees resetn rise close to a clock edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] rv;
    logic [7:0] wv;
    logic [7:0] mask;
    logic [1:0] code;
    pfs_route_t r;
    int         p;
    int         b;
    rv      = 8'h00;
    wv      = 8'h00;
    mask    = 8'h00;
    code    = CODE_GPIO;
    r       = '{PFS_FN_GPIO, 5'h00};
    p       = 0;
    b       = 0;
    next_st = st;

    // read view; port data reads the pad for inputs, the latch for outputs
    if (addr <= ADDR_SEL_D) begin
      rv = st.sel[addr[2:0]];
    end else if (addr == ADDR_IN_ROUTE) begin
      rv = {6'h00, st.in_route};
    end else if (addr >= ADDR_DATA_A && addr <= ADDR_DATA_D) begin
      p  = int'(addr - ADDR_DATA_A);
      rv = (pin_byte[p] & st.dir[p]) | (st.data[p] & ~st.dir[p]);
    end else if (addr >= ADDR_DIR_A && addr <= ADDR_DIR_D) begin
      rv = st.dir[int'(addr - ADDR_DIR_A)];
    end else if (addr == ADDR_WAKE_EN) begin
      rv = st.wake_en;
    end

    // write, plain or bit-wise from the full port view
    // a bit op copies pad levels of input bits into their latches; software
    // that mixes inputs and outputs on one port must rewrite the latch after
    wv = wdata;
    if (bit_set || bit_clr) begin
      mask = 8'h01 << wdata[2:0];
      wv   = bit_set ? (rv | mask) : (rv & ~mask);
    end
    if (wr) begin
      if (addr < ADDR_SEL_D) begin
        next_st.sel[addr[2:0]] = wv;
      end else if (addr == ADDR_SEL_D) begin
        next_st.sel[addr[2:0]] = wv & SEL_D_MASK;
      end else if (addr == ADDR_IN_ROUTE) begin
        next_st.in_route = wv[1:0];
      end else if (addr >= ADDR_DATA_A && addr < ADDR_DATA_D) begin
        next_st.data[int'(addr - ADDR_DATA_A)] = wv;
      end else if (addr == ADDR_DATA_D) begin
        next_st.data[int'(addr - ADDR_DATA_A)] = wv & PORT_D_MASK;
      end else if (addr >= ADDR_DIR_A && addr < ADDR_DIR_D) begin
        next_st.dir[int'(addr - ADDR_DIR_A)] = wv;
      end else if (addr == ADDR_DIR_D) begin
        next_st.dir[int'(addr - ADDR_DIR_A)] = wv | ~PORT_D_MASK;
      end else if (addr == ADDR_WAKE_EN) begin
        next_st.wake_en = wv;
      end
    end
    next_st.rdata = rd ? rv : 8'h00;

    // pin routing from the values being written, so pads follow next edge
    // analog functions only release the pad and raise a switch enable; the
    // switches themselves sit in the pad ring
    next_st.analog = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      p    = i / PORT_W;
      b    = i % PORT_W;
      code = next_st.sel[i / PINS_PER_REG][SEL_W * (i % PINS_PER_REG) +: SEL_W];
      r    = route(i, code);
      next_st.pin_out[i]  = 1'b0;
      next_st.pin_oe_n[i] = 1'b1;
      case (r.fn)
        PFS_FN_GPIO: begin
          next_st.pin_out[i]  = next_st.data[p][b];
          next_st.pin_oe_n[i] = next_st.dir[p][b];
        end
        PFS_FN_LCDF: begin
          next_st.pin_out[i]  = drive.lcd_frontplane_lines[r.idx];
          next_st.pin_oe_n[i] = 1'b0;
        end
        PFS_FN_LCDB: begin
          next_st.pin_out[i]  = drive.lcd_backplane_lines[r.idx[1:0]];
          next_st.pin_oe_n[i] = 1'b0;
        end
        PFS_FN_ADC: begin
          next_st.analog.adc_inputs[r.idx[1:0]] = 1'b1;
        end
        PFS_FN_VREF: begin
          next_st.analog.vref = 1'b1;
        end
        PFS_FN_XTAL: begin
          next_st.analog.crystal[r.idx[0]] = 1'b1;
        end
        PFS_FN_TX: begin
          next_st.pin_out[i]  = drive.uart_tx;
          next_st.pin_oe_n[i] = 1'b0;
        end
        PFS_FN_AUX: begin
          next_st.pin_out[i]  = drive.auxiliary_output_function;
          next_st.pin_oe_n[i] = 1'b0;
        end
        PFS_FN_TMR: begin
          next_st.pin_out[i]  = drive.timer_output;
          next_st.pin_oe_n[i] = 1'b0;
        end
        PFS_FN_TMRN: begin
          next_st.pin_out[i]  = ~drive.timer_output;
          next_st.pin_oe_n[i] = 1'b0;
        end
        PFS_FN_RX: begin
          next_st.pin_oe_n[i] = 1'b1;
        end
        default: begin
          next_st.pin_oe_n[i] = 1'b1;
        end
      endcase
    end

    // input routing; direction must be input for these, left to software
    next_st.periph.uart_rx = next_st.in_route[RX_SRC_BIT] ?
                             pin_in[PIN_C4] : pin_in[PIN_A6];
    next_st.periph.irq_in  = next_st.in_route[IRQ_SRC_BIT] ?
                             pin_in[PIN_C6] : pin_in[PIN_B3];
    next_st.periph.timer_clock_pin = pin_in[PIN_A7];

    // wake only from pins that are plain GPIO inputs
    // the wake pulse uses current selects, not the one being written: a
    // select write and a falling pad in one cycle do not race
    next_st.wake    = 1'b0;
    next_st.pa_prev = pin_in[PIN_A7:PIN_A0];
    for (int i = 0; i < PORT_W; i++) begin
      code = st.sel[i / PINS_PER_REG][SEL_W * (i % PINS_PER_REG) +: SEL_W];
      r    = route(i, code);
      if (sleep && st.wake_en[i] && r.fn == PFS_FN_GPIO && st.dir[0][i] &&
          st.pa_prev[i] && !pin_in[i]) begin
        next_st.wake = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // rst_n is the synchronised copy, so reset ends on a clock edge for all state but the synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata    = st.rdata;
  assign pin_out  = st.pin_out;
  assign pin_oe_n = st.pin_oe_n;
  assign periph   = st.periph;
  assign analog   = st.analog;
  assign wake     = st.wake;

endmodule

/* File: pfs_mux_properties.sv */
// pfs_mux_properties: concurrent checks on the pin function mux ports.
// assumes the bench never uses bit set/clear on selection registers.
`timescale 1ns/10ps
module pfs_mux_properties
  import pfs_pkg::*;
(
  input wire logic                ref_clk,  // system clock
  input wire logic                resetn,   // async reset, active low
  input wire logic [7:0]          addr,     // register address
  input wire logic [7:0]          wdata,    // write data
  input wire logic                wr,       // write strobe
  input wire logic                rd,       // read strobe
  input wire logic                bit_set,  // bit set qualifier
  input wire logic                bit_clr,  // bit clear qualifier
  input wire logic [7:0]          rdata,    // read data
  input wire logic [NUM_PINS-1:0] pin_in,   // pad levels
  input wire logic [NUM_PINS-1:0] pin_out,  // pad drive levels
  input wire logic [NUM_PINS-1:0] pin_oe_n, // pad enable
  input wire pfs_pkg::pfs_drive_t drive,    // peripheral levels
  input wire pfs_pkg::pfs_periph_t periph,  // routed inputs
  input wire pfs_pkg::pfs_analog_t analog,  // analog enables
  input wire logic                sleep,    // sleep mode
  input wire logic                wake      // wake pulse
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic [2:0] rel_sh;
  logic       live;
  logic [7:0] route_q;
  logic [7:0] route_n;
  logic [7:0] seld_q;
  logic [7:0] seld_n;

  // internal reset lags resetn by two flops, so checks start one edge later
  assign live = rel_sh[2];

  always_comb begin
    route_n = route_q;
    seld_n  = seld_q;
    if (wr && addr == ADDR_IN_ROUTE) route_n = wdata & IN_ROUTE_MASK;
    if (wr && addr == ADDR_SEL_D) seld_n = wdata & SEL_D_MASK;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rel_sh  <= 3'h0;
      route_q <= 8'h00;
      seld_q  <= 8'h00;
    end else begin
      rel_sh  <= {rel_sh[1:0], 1'b1};
      route_q <= route_n;
      seld_q  <= seld_n;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn || !live);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_RX_SRC: assert property (
    periph.uart_rx == ($past(route_n[RX_SRC_BIT]) ? $past(pin_in[PIN_C4]) : $past(pin_in[PIN_A6])))
    else $error("uart receive source wrong");
  AST_IRQ_SRC: assert property (
    periph.irq_in == ($past(route_n[IRQ_SRC_BIT]) ? $past(pin_in[PIN_C6]) : $past(pin_in[PIN_B3])))
    else $error("interrupt source wrong");
  AST_TMR_CLK: assert property (
    periph.timer_clock_pin == $past(pin_in[PIN_A7])) else $error("timer clock not from A7");
  AST_ROUTE_RD: assert property (
    rd && addr == ADDR_IN_ROUTE |=> rdata[7:2] == 6'h00) else $error("routing upper bits set");
  AST_SELD_RD: assert property (
    rd && addr == ADDR_SEL_D |=> rdata[7:4] == 4'h0) else $error("port d select upper bits set");
  AST_WAKE: assert property (
    wake |-> $past(sleep) && (($past(pin_in[7:0], 2) & ~$past(pin_in[7:0])) != 8'h00))
    else $error("wake without falling edge in sleep");
  AST_D0_TMR: assert property (
    $past(seld_n[1:0]) == CODE_ALT |-> !pin_oe_n[PIN_D0] && pin_out[PIN_D0] == $past(drive.timer_output))
    else $error("d0 timer output wrong");
  AST_D0_TMRN: assert property (
    $past(seld_n[1:0]) == CODE_ALT2 |-> !pin_oe_n[PIN_D0] && pin_out[PIN_D0] != $past(drive.timer_output))
    else $error("d0 inverted timer output wrong");
  AST_D1_LCD: assert property (
    $past(seld_n[3:2]) == CODE_LCD |-> !pin_oe_n[25] && pin_out[25] == $past(drive.lcd_frontplane_lines[8]))
    else $error("d1 frontplane line wrong");
  AST_RESET_PADS: assert property (@(posedge ref_clk) disable iff (!resetn)
    !live |-> pin_oe_n == '1 && pin_out == '1 && analog == '0) else $error("pads not idle in reset");

  CV_WAKE: cover property (wake);
  CV_D0_INV: cover property ($past(seld_n[1:0]) == CODE_ALT2);
  CV_RX_C4: cover property (route_q[RX_SRC_BIT] && periph.uart_rx);
endmodule

/* File: pfs_note_end.sv */
`timescale 1ns/10ps

/* File: pfs_pkg.sv */
// pfs_pkg: constants, register map and carrier types of the pin function mux.
// assumes a single 125 MHz clock and a simple strobe-based register port.
package pfs_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_PINS      = 26;
  localparam int NUM_PORTS     = 4;
  localparam int PORT_W        = 8;
  localparam int NUM_SEL       = 7;
  localparam int SEL_W         = 2;
  localparam int PINS_PER_REG  = 4;
  localparam int NUM_LCDF      = 20;
  localparam int NUM_LCDB      = 4;
  localparam int NUM_ADC       = 4;
  localparam int NUM_XTAL      = 2;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SEL_A_LO = 8'h00;
  localparam logic [7:0] ADDR_SEL_A_HI = 8'h01;
  localparam logic [7:0] ADDR_SEL_B_LO = 8'h02;
  localparam logic [7:0] ADDR_SEL_B_HI = 8'h03;
  localparam logic [7:0] ADDR_SEL_C_LO = 8'h04;
  localparam logic [7:0] ADDR_SEL_C_HI = 8'h05;
  localparam logic [7:0] ADDR_SEL_D    = 8'h06;
  localparam logic [7:0] ADDR_IN_ROUTE = 8'h08;
  localparam logic [7:0] ADDR_DATA_A   = 8'h10;
  localparam logic [7:0] ADDR_DATA_D   = 8'h13;
  localparam logic [7:0] ADDR_DIR_A    = 8'h14;
  localparam logic [7:0] ADDR_DIR_D    = 8'h17;
  localparam logic [7:0] ADDR_WAKE_EN  = 8'h18;

  // ----------------------------------------------------------------
  // masks, fields, reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_D_MASK    = 8'h0F;
  localparam logic [7:0] IN_ROUTE_MASK = 8'h03;
  localparam logic [7:0] PORT_D_MASK   = 8'h03;
  localparam int         RX_SRC_BIT    = 0;
  localparam int         IRQ_SRC_BIT   = 1;
  localparam logic [7:0] SEL_RESET     = 8'h00;
  localparam logic [7:0] PORT_RESET    = 8'hFF;
  localparam logic [1:0] CODE_GPIO     = 2'h0;
  localparam logic [1:0] CODE_LCD      = 2'h1;
  localparam logic [1:0] CODE_ALT      = 2'h2;
  localparam logic [1:0] CODE_ALT2     = 2'h3;

  // ----------------------------------------------------------------
  // pin indices (A0..A7, B0..B7, C0..C7, D0..D1)
  // ----------------------------------------------------------------
  localparam int PIN_A0 = 0;
  localparam int PIN_A6 = 6;
  localparam int PIN_A7 = 7;
  localparam int PIN_B3 = 11;
  localparam int PIN_C4 = 20;
  localparam int PIN_C6 = 22;
  localparam int PIN_D0 = 24;

  typedef enum logic [3:0] {
    PFS_FN_GPIO, PFS_FN_LCDF, PFS_FN_LCDB, PFS_FN_ADC, PFS_FN_VREF, PFS_FN_XTAL,
    PFS_FN_TX, PFS_FN_RX, PFS_FN_AUX, PFS_FN_TMR, PFS_FN_TMRN
  } pfs_fn_t;

  typedef struct packed {
    pfs_fn_t    fn;
    logic [4:0] idx;
  } pfs_route_t;

  // levels that peripherals want on pins
  typedef struct packed {
    logic [NUM_LCDF-1:0] lcd_frontplane_lines;
    logic [NUM_LCDB-1:0] lcd_backplane_lines;
    logic                uart_tx;
    logic                auxiliary_output_function;
    logic                timer_output;
  } pfs_drive_t;

  // digital inputs handed to peripherals
  typedef struct packed {
    logic uart_rx;
    logic irq_in;
    logic timer_clock_pin;
  } pfs_periph_t;

  // analog switch enables
  typedef struct packed {
    logic [NUM_ADC-1:0]  adc_inputs;
    logic                vref;
    logic [NUM_XTAL-1:0] crystal;
  } pfs_analog_t;

endpackage

/* File: tb.sv */
// tb: register-level checks of pin selection, routing, ports and wake-up.
// assumes the design alone; the bench drives pads and peripheral levels.
`timescale 1ns/10ps
module tb;
  import pfs_pkg::*;
  logic ref_clk, resetn, wr, rd, bit_set, bit_clr, sleep, wake;
  logic [7:0] addr, wdata, rdata;
  logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe_n;
  pfs_drive_t drive;
  pfs_periph_t periph;
  pfs_analog_t analog, ea;
  int miscompares, n_tests, cyc;
  // -2 crystal, 20+ backplane, else frontplane line
  int lcd_map [26] = '{-2,15,-2,14,13,12,11,10,16,17,18,19,20,21,22,23,0,1,2,3,4,5,6,7,9,8};
  // code 10: 1 analog or input, 2 transmit, 3 auxiliary, 4 timer
  int alt_map [26] = '{0,1,0,1,3,2,1,0,1,1,1,0,0,0,0,0,0,0,0,0,1,2,0,0,4,0};

  pfs_mux DUT (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .bit_set(bit_set), .bit_clr(bit_clr), .rdata(rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .drive(drive), .periph(periph),
    .analog(analog), .sleep(sleep), .wake(wake));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic bit_op(input logic [7:0] a, input logic [7:0] idx, input logic s);
    @(posedge ref_clk);
    addr <= a; wdata <= idx; wr <= 1'b1; bit_set <= s; bit_clr <= !s;
    @(posedge ref_clk);
    wr <= 1'b0; bit_set <= 1'b0; bit_clr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a; rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp, "register read");
  endtask

  task automatic fall_chk(input int idx, input logic slp, input logic exp);
    @(posedge ref_clk);
    pin_in[idx] <= 1'b1; sleep <= slp;
    repeat (2) @(posedge ref_clk);
    pin_in[idx] <= 1'b0;
    @(posedge ref_clk);
    #1;
    check(wake, exp, "wake pulse");
    @(posedge ref_clk);
    #1;
    check(wake, 1'b0, "wake one cycle");
  endtask

  // gpio here means dir input and latch high, so the pad stays released
  function automatic logic [1:0] exp_pin(input int p, input logic [1:0] c);
    int m;
    m = lcd_map[p];
    if (c == CODE_LCD) begin
      if (m == -2) return 2'b10;
      if (m >= 20) return {1'b0, drive.lcd_backplane_lines[m-20]};
      return {1'b0, drive.lcd_frontplane_lines[m]};
    end
    if (c == CODE_ALT) begin
      case (alt_map[p])
        1: return 2'b10;
        2: return {1'b0, drive.uart_tx};
        3: return {1'b0, drive.auxiliary_output_function};
        4: return {1'b0, drive.timer_output};
        default: ;
      endcase
    end
    if (c == CODE_ALT2 && p == PIN_D0) return {1'b0, ~drive.timer_output};
    return 2'b11;
  endfunction

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] wd;
    resetn = 1'b0; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    bit_set = 1'b0; bit_clr = 1'b0; sleep = 1'b0; pin_in = '1;
    drive = '{lcd_frontplane_lines: 20'hA35C6, lcd_backplane_lines: 4'h6, uart_tx: 1'b1,
              auxiliary_output_function: 1'b0, timer_output: 1'b0};
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check(pin_oe_n, 26'h3FFFFFF, "pads released after reset");
    for (int i = 0; i <= 8; i++) rd_chk(8'(i), 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'(ADDR_DATA_A + i), (i == 3) ? 8'h03 : 8'hFF);
      rd_chk(8'(ADDR_DIR_A + i), 8'hFF);
    end
    wr_reg(8'h07, 8'hFF);
    rd_chk(8'h07, 8'h00);
    for (int r = 0; r < NUM_SEL; r++) begin
      for (int c = 0; c < 4; c++) begin
        // peripheral levels move a cycle before each selection write, never with it
        @(posedge ref_clk);
        drive <= ~drive;
        wd = {4{2'(c)}};
        wr_reg(8'(r), wd);
        for (int k = 0; k < 4; k++) begin
          if (r * 4 + k < NUM_PINS)
            check({pin_oe_n[r*4+k], pin_out[r*4+k]}, exp_pin(r * 4 + k, 2'(c)), "pin");
        end
        ea = '0;
        if (r == 0 && c == 1) ea.crystal = 2'h3;
        if (r == 0 && c == 2) begin
          ea.adc_inputs[0] = 1'b1;
          ea.vref = 1'b1;
        end
        if (r == 2 && c == 2) ea.adc_inputs[3:1] = 3'h7;
        check(analog, ea, "analog enables");
        rd_chk(8'(r), (r == 6) ? (wd & SEL_D_MASK) : wd);
      end
    end
    // direction bits are still inputs from reset, as software must leave them
    @(posedge ref_clk);
    pin_in[PIN_A6] <= 1'b0; pin_in[PIN_C4] <= 1'b1; pin_in[PIN_B3] <= 1'b1;
    pin_in[PIN_C6] <= 1'b0; pin_in[PIN_A7] <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      wr_reg(ADDR_IN_ROUTE, 8'(r));
      check(periph.uart_rx, r[0], "receive source");
      check(periph.irq_in, !r[1], "interrupt source");
    end
    check(periph.timer_clock_pin, 1'b0, "timer clock");
    wr_reg(ADDR_IN_ROUTE, 8'hFF);
    rd_chk(ADDR_IN_ROUTE, 8'h03);
    wr_reg(ADDR_DIR_A, 8'h00);
    check(pin_oe_n[7:0], 8'h00, "port a driving");
    check(pin_out[7:0], 8'hFF, "port a starts high");
    wr_reg(ADDR_DATA_A, 8'h5A);
    check(pin_out[7:0], 8'h5A, "port a latch");
    rd_chk(ADDR_DATA_A, 8'h5A);
    wr_reg(ADDR_DIR_A, 8'hFF);
    check(pin_oe_n[7:0], 8'hFF, "port a released");
    @(posedge ref_clk);
    pin_in[15:8] <= 8'h00;
    wr_reg(8'h15, 8'h0F);
    bit_op(8'h11, 8'h07, 1'b0);
    wr_reg(8'h15, 8'h00);
    check(pin_out[15:8], 8'h70, "clear rewrites whole port");
    bit_op(8'h11, 8'h00, 1'b1);
    check(pin_out[15:8], 8'h71, "set rewrites whole port");
    wr_reg(ADDR_WAKE_EN, 8'h01);
    fall_chk(0, 1'b0, 1'b0);
    fall_chk(1, 1'b1, 1'b0);
    fall_chk(0, 1'b1, 1'b1);
    give_verdict();
  end
endmodule

bind pfs_mux pfs_mux_properties u_props (.ref_clk(ref_clk), .resetn(resetn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .bit_set(bit_set), .bit_clr(bit_clr), .rdata(rdata),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .drive(drive),
  .periph(periph), .analog(analog), .sleep(sleep), .wake(wake));
